/* hw/level_map_pkg.sv */
// constants and types shared by the interrupt level map design
package level_map_pkg;

   localparam int ADDR_W  = 32;
   localparam int DATA_W  = 32;
   localparam int STRB_W  = DATA_W / 8;
   localparam int LEVEL_W = 3;
   localparam int NUM_SRC = 15;

   // register byte addresses
   localparam logic [ADDR_W-1:0] OFS_SIGNALS_MONITORS = 32'hfff4007c;
   localparam logic [ADDR_W-1:0] OFS_SOFTWARE_IRQS    = 32'hfff40080;
   localparam logic [ADDR_W-1:0] OFS_BACKPLANE_IRQS   = 32'hfff40084;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS       = 32'hfff40090;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR        = 32'hfff40094;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE       = 32'hfff40098;

   // six used bits in each byte lane, room for two level fields per lane
   localparam logic [DATA_W-1:0] LEVEL_USED_MASK = 32'h3f3f3f3f;
   localparam logic [DATA_W-1:0] LEVEL_RESET     = 32'h00000000;
   localparam logic [NUM_SRC-1:0] IRQ_ENABLE_RESET = 15'h0000;
   localparam logic [NUM_SRC-1:0] IRQ_STATUS_RESET = 15'h0000;
   localparam logic [LEVEL_W-1:0] LEVEL_NONE      = 3'h0;
   localparam int SPARE_LSB = 27;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // which level register holds a source's field
   typedef enum logic [1:0] {
      SEL_SIGNALS_MONITORS = 2'b00,
      SEL_SOFTWARE_IRQS    = 2'b01,
      SEL_BACKPLANE_IRQS   = 2'b10
   } level_reg_sel_t;

   // sources: signal0, signal1, monitor0, monitor1, soft0..soft7, backplane 5, 6, 7
   localparam level_reg_sel_t SRC_REG [NUM_SRC] = '{
      SEL_SIGNALS_MONITORS, SEL_SIGNALS_MONITORS, SEL_SIGNALS_MONITORS, SEL_SIGNALS_MONITORS,
      SEL_SOFTWARE_IRQS, SEL_SOFTWARE_IRQS, SEL_SOFTWARE_IRQS, SEL_SOFTWARE_IRQS,
      SEL_SOFTWARE_IRQS, SEL_SOFTWARE_IRQS, SEL_SOFTWARE_IRQS, SEL_SOFTWARE_IRQS,
      SEL_BACKPLANE_IRQS, SEL_BACKPLANE_IRQS, SEL_BACKPLANE_IRQS};
   localparam int SRC_LSB [NUM_SRC] = '{8, 11, 0, 3, 0, 3, 8, 11, 16, 19, 24, 27, 16, 19, 24};

endpackage

/* hw/reg_access_if.sv */
// register access strobes between the bus slave and the register file
`timescale 1ns/1ps
interface reg_access_if
   import level_map_pkg::*;
   ();
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [STRB_W-1:0] wr_strb;
   logic              wr_ok;
   logic              rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic              rd_ok;

   modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_ok, rd_data, rd_ok);
   modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface

/* hw/axi_lite_slave.sv */
// axi4-lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
module axi_lite_slave
   import level_map_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [STRB_W-1:0] wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [DATA_W-1:0]      rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   reg_access_if.bus              acc
);
   logic              aw_full_reg;
   logic              w_full_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [DATA_W-1:0] w_data_reg;
   logic [STRB_W-1:0] w_strb_reg;
   logic              awready_reg;
   logic              wready_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   logic              arready_reg;
   logic              rvalid_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [1:0]        rresp_reg;

   // address and data are taken in either order; the write fires once both are held
   wire aw_hs        = awvalid & awready_reg;
   wire w_hs         = wvalid & wready_reg;
   wire do_wr        = aw_full_reg & w_full_reg & ~bvalid_reg;
   wire aw_full_next = (aw_full_reg | aw_hs) & ~do_wr;
   wire w_full_next  = (w_full_reg | w_hs) & ~do_wr;
   wire bvalid_next  = do_wr | (bvalid_reg & ~bready);
   wire ar_hs        = arvalid & arready_reg;
   wire rvalid_next  = ar_hs | (rvalid_reg & ~rready);

   assign acc.wr_en   = do_wr;
   assign acc.wr_addr = aw_addr_reg;
   assign acc.wr_data = w_data_reg;
   assign acc.wr_strb = w_strb_reg;
   assign acc.rd_en   = ar_hs;
   assign acc.rd_addr = araddr;

   // write channel state; ready drops while a write is held or answered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
         w_strb_reg  <= '0;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg  <= w_full_next;
         awready_reg <= ~aw_full_next & ~bvalid_next;
         wready_reg  <= ~w_full_next & ~bvalid_next;
         bvalid_reg  <= bvalid_next;
         if (aw_hs) aw_addr_reg <= awaddr;
         if (w_hs) begin
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end
         if (do_wr) bresp_reg <= acc.wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // read channel; data is captured in the cycle the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= RESP_OKAY;
      end else begin
         arready_reg <= ~rvalid_next;
         rvalid_reg  <= rvalid_next;
         if (ar_hs) begin
            rdata_reg <= acc.rd_data;
            rresp_reg <= acc.rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   assign awready = awready_reg;
   assign wready  = wready_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign arready = arready_reg;
   assign rvalid  = rvalid_reg;
   assign rdata   = rdata_reg;
   assign rresp   = rresp_reg;
endmodule

/* hw/level_resolver.sv */
// picks the highest level among presented sources
`timescale 1ns/1ps
module level_resolver
   import level_map_pkg::*;
#(
   parameter int N = NUM_SRC
) (
   input  wire logic [N-1:0]              active,
   input  wire logic [N-1:0][LEVEL_W-1:0] level,
   output logic [LEVEL_W-1:0]             top_level
);
   // a zero field never wins, so such a source does not change top_level
   always_comb begin
      top_level = LEVEL_NONE;
      for (int i = 0; i < N; i++) begin
         if (active[i] && level[i] > top_level) top_level = level[i];
      end
   end
endmodule

/* hw/interrupt_level_map.sv */
// interrupt level map registers with source status, enable and level output
`timescale 1ns/1ps

// Notes on behaviour
// - bits 15:8 of the signals/monitors register hold the signal0 and signal1 levels.
// - bits 7:0 of the signals/monitors register hold the monitor0 and monitor1 levels.
// - bits 31:24 of the software register hold the soft 6 and soft 7 levels.
// - bits 23:16 of the software register hold the soft 4 and soft 5 levels.
// - bits 15:8 of the software register hold the soft 2 and soft 3 levels.
// - bits 7:0 of the software register hold the soft 0 and soft 1 levels.
// - bits 31:24 of the backplane register hold the request 7 level beside a spare field.
// - the spare field is stored but never affects interrupt generation.
// - bits 23:16 of the backplane register hold the request 5 and 6 levels.
// - every backplane request may be routed to any local level through its field.
// - each byte lane uses six bits, all readable and writable; bits 31:16 of signals/monitors and 15:0 of backplane hold no field.
module interrupt_level_map
   import level_map_pkg::*;
(
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [DATA_W-1:0]  s_axi_wdata,
   input  wire logic [STRB_W-1:0]  s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [ADDR_W-1:0]  s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic [NUM_SRC-1:0] source_request,
   output logic [LEVEL_W-1:0]      irq_level,
   output logic                    irq
);
   reg_access_if acc ();

   logic [DATA_W-1:0]               signals_monitors_reg;
   logic [DATA_W-1:0]               software_irqs_reg;
   logic [DATA_W-1:0]               backplane_irqs_reg;
   logic [NUM_SRC-1:0]              request_prev_reg;
   logic [NUM_SRC-1:0]              irq_status_reg;
   logic [NUM_SRC-1:0]              irq_enable_reg;
   logic [LEVEL_W-1:0]              irq_level_reg;
   logic                            irq_reg;
   logic [NUM_SRC-1:0][LEVEL_W-1:0] source_level;
   logic [LEVEL_W-1:0]              top_level;

   // byte-lane merge, used for every level register
   function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_val,
                                                    input logic [DATA_W-1:0] new_val,
                                                    input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] res;
      res = old_val;
      for (int b = 0; b < STRB_W; b++) begin
         if (strb[b]) res[b*8 +: 8] = new_val[b*8 +: 8];
      end
      return res & LEVEL_USED_MASK;
   endfunction

   axi_lite_slave u_bus (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .acc     (acc)
   );

   // write address decode
   wire wr_sigmon = acc.wr_en && acc.wr_addr == OFS_SIGNALS_MONITORS;
   wire wr_soft   = acc.wr_en && acc.wr_addr == OFS_SOFTWARE_IRQS;
   wire wr_back   = acc.wr_en && acc.wr_addr == OFS_BACKPLANE_IRQS;
   wire wr_clear  = acc.wr_en && acc.wr_addr == OFS_IRQ_CLEAR;
   wire wr_enable = acc.wr_en && acc.wr_addr == OFS_IRQ_ENABLE;
   // status is read-only, so a write to it is refused like an unmapped one
   assign acc.wr_ok = wr_sigmon | wr_soft | wr_back | wr_clear | wr_enable;

   // level registers, six bits per lane, cleared by reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         signals_monitors_reg <= LEVEL_RESET;
         software_irqs_reg    <= LEVEL_RESET;
         backplane_irqs_reg   <= LEVEL_RESET;
      end else begin
         if (wr_sigmon) signals_monitors_reg <= lane_merge(signals_monitors_reg, acc.wr_data, acc.wr_strb);
         if (wr_soft) software_irqs_reg <= lane_merge(software_irqs_reg, acc.wr_data, acc.wr_strb);
         if (wr_back) backplane_irqs_reg <= lane_merge(backplane_irqs_reg, acc.wr_data, acc.wr_strb);
      end
   end

   // each source's three-bit field; the spare field at SPARE_LSB feeds nothing
   for (genvar s = 0; s < NUM_SRC; s++) begin : g_field
      wire [DATA_W-1:0] holder = (SRC_REG[s] == SEL_SIGNALS_MONITORS) ? signals_monitors_reg :
                                 (SRC_REG[s] == SEL_SOFTWARE_IRQS)    ? software_irqs_reg :
                                                                        backplane_irqs_reg;
      assign source_level[s] = holder[SRC_LSB[s] +: LEVEL_W];
   end

   // events are request rising edges; a new event wins over a clear in the same cycle
   wire [NUM_SRC-1:0] request_rise  = source_request & ~request_prev_reg;
   wire [NUM_SRC-1:0] clear_bits    = wr_clear ? acc.wr_data[NUM_SRC-1:0] : '0;
   wire [NUM_SRC-1:0] status_next   = (irq_status_reg & ~clear_bits) | request_rise;
   wire [NUM_SRC-1:0] enable_next   = wr_enable ? acc.wr_data[NUM_SRC-1:0] : irq_enable_reg;
   wire [NUM_SRC-1:0] presented     = irq_status_reg & irq_enable_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         request_prev_reg <= '0;
         irq_status_reg   <= IRQ_STATUS_RESET;
         irq_enable_reg   <= IRQ_ENABLE_RESET;
      end else begin
         request_prev_reg <= source_request;
         irq_status_reg   <= status_next;
         irq_enable_reg   <= enable_next;
      end
   end

   level_resolver #(
      .N (NUM_SRC)
   ) u_resolve (
      .active    (presented),
      .level     (source_level),
      .top_level (top_level)
   );

   // outputs straight from flops; a zero level keeps a source off the level output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_level_reg <= LEVEL_NONE;
         irq_reg       <= 1'b0;
      end else begin
         irq_level_reg <= top_level;
         irq_reg       <= |presented;
      end
   end

   assign irq_level = irq_level_reg;
   assign irq       = irq_reg;

   // read decode; clear register is write-only and reads as zero
   wire rd_sigmon = acc.rd_addr == OFS_SIGNALS_MONITORS;
   wire rd_soft   = acc.rd_addr == OFS_SOFTWARE_IRQS;
   wire rd_back   = acc.rd_addr == OFS_BACKPLANE_IRQS;
   wire rd_status = acc.rd_addr == OFS_IRQ_STATUS;
   wire rd_clear  = acc.rd_addr == OFS_IRQ_CLEAR;
   wire rd_enable = acc.rd_addr == OFS_IRQ_ENABLE;
   assign acc.rd_ok   = rd_sigmon | rd_soft | rd_back | rd_status | rd_clear | rd_enable;
   assign acc.rd_data = rd_sigmon ? signals_monitors_reg :
                        rd_soft   ? software_irqs_reg :
                        rd_back   ? backplane_irqs_reg :
                        rd_status ? {{(DATA_W-NUM_SRC){1'b0}}, irq_status_reg} :
                        rd_enable ? {{(DATA_W-NUM_SRC){1'b0}}, irq_enable_reg} :
                                    '0;
endmodule

/* test/level_map_checker.sv */
// port-level assertions for the interrupt level map
`timescale 1ns/1ps
module level_map_checker
   import level_map_pkg::*;
(
   input wire logic               aclk,
   input wire logic               aresetn,
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_wready,
   input wire logic [1:0]         s_axi_bresp,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic [ADDR_W-1:0]  s_axi_araddr,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic [DATA_W-1:0]  s_axi_rdata,
   input wire logic [1:0]         s_axi_rresp,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   input wire logic [LEVEL_W-1:0] irq_level,
   input wire logic               irq
);
   logic [ADDR_W-1:0] ar_seen_reg;
   logic              lvl_addr;
   logic              bad_addr;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // read data comes after arvalid drops, so keep the address
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ar_seen_reg <= '0;
      else if (s_axi_arvalid && s_axi_arready)
         ar_seen_reg <= s_axi_araddr;
   end

   // decode of the remembered read address
   assign lvl_addr = ar_seen_reg == OFS_SIGNALS_MONITORS || ar_seen_reg == OFS_SOFTWARE_IRQS
                     || ar_seen_reg == OFS_BACKPLANE_IRQS;
   assign bad_addr = !lvl_addr && ar_seen_reg != OFS_IRQ_STATUS && ar_seen_reg != OFS_IRQ_CLEAR
                     && ar_seen_reg != OFS_IRQ_ENABLE;

   a_write_resp_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response not two cycles after transfer");
   a_read_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after address");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before handshake");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before handshake");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");
   a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_level_needs_irq: assert property (irq_level != LEVEL_NONE |-> irq)
      else $error("level presented without interrupt");
   a_lane_bits_zero: assert property (s_axi_rvalid && lvl_addr |-> (s_axi_rdata & ~LEVEL_USED_MASK) == '0
      && s_axi_rresp == RESP_OKAY) else $error("unused lane bits read nonzero");
   a_unmapped_read: assert property (s_axi_rvalid && bad_addr |-> s_axi_rresp == RESP_SLVERR
      && s_axi_rdata == '0) else $error("unmapped read not refused");
endmodule

bind interrupt_level_map level_map_checker u_level_map_checker (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .irq_level, .irq);

/* test/interrupt_level_map_tb_top.sv */
// self-checking bench for the interrupt level map
`timescale 1ns/1ps
module interrupt_level_map_tb_top
   import level_map_pkg::*;
;
   logic               aclk = 0, aresetn = 0;
   logic [ADDR_W-1:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [DATA_W-1:0]  s_axi_wdata = '0, s_axi_rdata;
   logic [STRB_W-1:0]  s_axi_wstrb = '0;
   logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0]         s_axi_bresp, s_axi_rresp;
   logic [NUM_SRC-1:0] source_request = '0;
   logic [LEVEL_W-1:0] irq_level;
   int                 err_count = 0, checks_done = 0, cyc = 0, seed = 62680;
   logic [DATA_W-1:0]  lvl_model [3];
   int                 field_lsb [NUM_SRC] = '{8, 11, 0, 3, 0, 3, 8, 11, 16, 19, 24, 27, 16, 19, 24};

   always #20 aclk = ~aclk;

   interrupt_level_map DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .source_request, .irq_level, .irq);

   task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      if (err_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // hang guard, the whole run needs well under a thousand cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end

   // address and data offered together, each released once taken
   task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                            input logic [STRB_W-1:0] s, output logic [1:0] resp);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      // each channel drops at the edge that takes it; the loop ends once both are gone
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!((s_axi_awvalid !== 1'b1 || s_axi_awready === 1'b1)
                   && (s_axi_wvalid !== 1'b1 || s_axi_wready === 1'b1)));
      repeat ($random(seed) & 3) @(posedge aclk);
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic read_check(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                             input logic [1:0] exp_resp);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      repeat ($random(seed) & 3) @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      check(what, s_axi_rdata, exp);
      check("read resp", {30'h0, s_axi_rresp}, {30'h0, exp_resp});
      s_axi_rready <= 1'b0;
   endtask

   // model keeps six bits per lane, the design must match it
   task automatic level_write(input int k, input logic [DATA_W-1:0] d, input logic [STRB_W-1:0] s);
      logic [1:0] r;
      for (int b = 0; b < STRB_W; b++)
         if (s[b])
            lvl_model[k][b*8 +: 8] = d[b*8 +: 8] & 8'h3f;
      axi_write(OFS_SIGNALS_MONITORS + ADDR_W'(4*k), d, s, r);
      check("level write resp", {30'h0, r}, 32'h0);
   endtask

   task automatic pulse(input logic [NUM_SRC-1:0] src);
      @(posedge aclk);
      source_request <= src;
      @(posedge aclk);
      source_request <= '0;
      repeat (3) @(posedge aclk);
   endtask

   initial begin
      logic [1:0] r;
      int         k, lv;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // reset values, then refusals at an unmapped word
      for (k = 0; k < 3; k++) begin
         lvl_model[k] = LEVEL_RESET;
         read_check("level reset", OFS_SIGNALS_MONITORS + ADDR_W'(4*k), 32'h0, RESP_OKAY);
      end
      read_check("status reset", OFS_IRQ_STATUS, 32'h0, RESP_OKAY);
      read_check("enable reset", OFS_IRQ_ENABLE, 32'h0, RESP_OKAY);
      read_check("unmapped read", 32'hfff40088, 32'h0, RESP_SLVERR);
      axi_write(32'hfff40088, 32'hffffffff, 4'hf, r);
      check("unmapped write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      // random words and lane enables, read back through the mask
      repeat (24) begin
         k = $unsigned($random(seed)) % 3;
         level_write(k, DATA_W'($random(seed)), STRB_W'($random(seed)));
         read_check("level readback", OFS_SIGNALS_MONITORS + ADDR_W'(4*k), lvl_model[k], RESP_OKAY);
      end
      // each source in turn, presented at its own field's level
      axi_write(OFS_IRQ_ENABLE, 32'h7fff, 4'hf, r);
      for (int i = 0; i < NUM_SRC; i++) begin
         k  = i < 4 ? 0 : (i < 12 ? 1 : 2);
         lv = i % 7 + 1;
         lvl_model[k][field_lsb[i] +: 3] = lv[2:0];
         if (k == 2)
            lvl_model[2][29:27] = 3'h7;
         level_write(k, lvl_model[k], 4'hf);
         pulse(NUM_SRC'(1) << i);
         check("irq raised", {31'h0, irq}, 32'h1);
         check("irq level", {29'h0, irq_level}, DATA_W'(lv));
         read_check("status bit", OFS_IRQ_STATUS, DATA_W'(1) << i, RESP_OKAY);
         axi_write(OFS_IRQ_CLEAR, DATA_W'(1) << i, 4'hf, r);
         repeat (2) @(posedge aclk);
         check("irq cleared", {31'h0, irq}, 32'h0);
      end
      // clear register is write-only and reads as zero
      read_check("clear reads zero", OFS_IRQ_CLEAR, 32'h0, RESP_OKAY);
      // level zero still raises irq, a masked source adds nothing
      lvl_model[0][10:8] = 3'h0;
      level_write(0, lvl_model[0], 4'hf);
      axi_write(OFS_IRQ_ENABLE, 32'h7fef, 4'hf, r);
      read_check("enable readback", OFS_IRQ_ENABLE, 32'h7fef, RESP_OKAY);
      pulse(15'h0011);
      check("irq level zero", {31'h0, irq}, 32'h1);
      check("hidden level", {29'h0, irq_level}, 32'h0);
      read_check("status two", OFS_IRQ_STATUS, 32'h11, RESP_OKAY);
      // status is read-only: a write is refused and changes nothing
      axi_write(OFS_IRQ_STATUS, 32'h7fff, 4'hf, r);
      check("status write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      read_check("status kept", OFS_IRQ_STATUS, 32'h11, RESP_OKAY);
      axi_write(OFS_IRQ_CLEAR, 32'h11, 4'hf, r);
      repeat (2) @(posedge aclk);
      check("irq idle", {31'h0, irq}, 32'h0);
      // raise signal1 at level 2, then a mid-run reset must drop it and clear every field
      pulse(15'h0002);
      check("irq before reset", {29'h0, irq_level}, 32'h2);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check("irq after reset", {31'h0, irq}, 32'h0);
      check("level after reset", {29'h0, irq_level}, 32'h0);
      for (k = 0; k < 3; k++) begin
         lvl_model[k] = LEVEL_RESET;
         read_check("field after reset", OFS_SIGNALS_MONITORS + ADDR_W'(4*k), lvl_model[k], RESP_OKAY);
      end
      read_check("status after reset", OFS_IRQ_STATUS, 32'h0, RESP_OKAY);
      read_check("enable after reset", OFS_IRQ_ENABLE, 32'h0, RESP_OKAY);
      tally_and_finish();
   end
endmodule
